/* common/cofg_pkg.sv */
// constants, register map and types of the close-onto-fault guard
package cofg_pkg;

  localparam int CLK_HZ = 20000000;
  localparam int TICK_PERIOD_US = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1000000 * TICK_PERIOD_US;

  localparam int RT_W = 21;
  localparam logic [20:0] RELEASE_DEFAULT_MS = 21'd1000;
  localparam logic [20:0] RELEASE_MAX_MS = 21'd1800000;

  localparam int SG_COUNT = 8;
  localparam int SG_W = 3;
  localparam int CNT_W = 32;
  localparam int STAMP_W = 32;
  localparam int REC_DEPTH = 12;
  localparam int REC_AGE_W = 4;
  localparam int REC_W = STAMP_W + 3 + SG_W + RT_W + RT_W;

  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_REMAIN = 8'h08;
  localparam logic [7:0] REG_ELAPSED = 8'h0c;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h10;
  localparam logic [7:0] REG_IRQ_MASK = 8'h14;
  localparam logic [7:0] REG_TIME = 8'h18;
  localparam logic [7:0] REG_LAST_EVENT = 8'h1c;
  localparam logic [7:0] REG_LAST_STAMP = 8'h20;
  localparam logic [7:0] REG_REC_SEL = 8'h24;
  localparam logic [7:0] REG_REC_INFO = 8'h28;
  localparam logic [7:0] REG_REC_STAMP = 8'h2c;
  localparam logic [7:0] REG_REC_REMAIN = 8'h30;
  localparam logic [7:0] REG_REC_ELAPSED = 8'h34;
  localparam logic [7:0] REG_CNT_BASE = 8'h40;
  localparam logic [7:0] REG_RELEASE_BASE = 8'h80;

  localparam int CTRL_FORCE_EN_BIT = 0;
  localparam int CTRL_FORCE_LSB = 1;
  localparam int CTRL_STORE_LSB = 4;
  localparam int CTRL_CNT_CLR_BIT = 8;
  localparam logic [1:0] STORE_SEL_RESET = 2'h3;

  // flag indexes; event bit 2*i is the ON event, 2*i+1 the OFF event
  localparam int FLAG_COUNT = 4;
  localparam int EV_W = 2 * FLAG_COUNT;
  localparam int FLAG_INIT = 0;
  localparam int FLAG_BLOCK = 1;
  localparam int FLAG_ACTIVE = 2;
  localparam int FLAG_TRIP = 3;

  typedef enum logic [1:0] {
    FORCE_NORMAL,
    FORCE_BLOCKED,
    FORCE_ACTIVE,
    FORCE_TRIP
  } cofg_force_type;

  typedef enum logic [2:0] {
    ST_NORMAL,
    ST_INIT,
    ST_ACTIVE,
    ST_TRIP,
    ST_BLOCKED
  } cofg_state_type;

endpackage

/* tb/cofg_far_side.sv */
// far-side stand-in: breaker close contact and protection start lines
`timescale 1ns/1ps
`default_nettype none
module cofg_far_side
#(
  parameter int CLOSE_HOLD = 6
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic close_cmd,
  input wire logic block_lvl,
  input wire logic start_lvl,
  output logic guard_activate_in,
  output logic guard_block_in,
  output logic guard_function_in
);
  logic [7:0] hold_cnt;
  // a close command holds the breaker contact up for a while, not one cycle
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      hold_cnt <= 8'h00;
    else if (close_cmd)
      hold_cnt <= 8'(CLOSE_HOLD);
    else if (hold_cnt != 8'h00)
      hold_cnt <= hold_cnt - 8'h01;
  end
  assign guard_activate_in = (hold_cnt != 8'h00);
  assign guard_block_in = block_lvl;
  assign guard_function_in = start_lvl;
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench of the close-onto-fault guard
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cofg_pkg::*;
  localparam int TK = 20;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic close_cmd = 1'b0;
  logic block_lvl = 1'b0;
  logic start_lvl = 1'b0;
  logic [2:0] sg = 3'h0;
  logic act_pin;
  logic blk_pin;
  logic fcn_pin;
  logic active_o;
  logic trip_o;
  logic irq;
  logic [20:0] remain;
  logic [2:0] cond;
  logic [7:0] ev_p;
  logic [7:0] ev_s;
  logic [7:0] seen_p;
  logic [7:0] seen_s;
  logic [31:0] stamp;
  logic [31:0] rd;
  int error_cnt = 0;
  int check_count = 0;

  always #25 core_clk = ~core_clk;

  always @(negedge core_clk)
  begin
    seen_p <= seen_p | ev_p;
    seen_s <= seen_s | ev_s;
  end

  cofg_far_side cofg_far_side_inst (.core_clk(core_clk), .rst_n(rst_n), .close_cmd(close_cmd),
    .block_lvl(block_lvl), .start_lvl(start_lvl), .guard_activate_in(act_pin),
    .guard_block_in(blk_pin), .guard_function_in(fcn_pin));

  cofg_guard #(.TICK_CYCLES_P(TK)) cofg_guard_inst (.core_clk(core_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .guard_activate_in(act_pin),
    .guard_block_in(blk_pin), .guard_function_in(fcn_pin), .setting_group_select(sg),
    .guard_active_out(active_o), .guard_trip_out(trip_o), .guard_time_remaining(remain),
    .condition_state(cond), .event_pulse(ev_p), .event_store(ev_s), .event_stamp(stamp),
    .irq(irq));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    chk("bus answer", 32'h0, {31'h0, avs_waitrequest});
    if (avs_waitrequest !== 1'b0)
      tally_and_finish();
  endtask

  task automatic wait_st(input logic [2:0] s, input int lim);
    int n;
    n = 0;
    while (cond !== s && n < lim)
    begin
      @(negedge core_clk);
      n++;
    end
    chk("condition", {29'h0, s}, {29'h0, cond});
    if (cond !== s)
      tally_and_finish();
  endtask

  task automatic arm();
    @(posedge core_clk);
    close_cmd <= 1'b1;
    @(posedge core_clk);
    close_cmd <= 1'b0;
  endtask

  task automatic t_reset();
    bus(1'b0, REG_RELEASE_BASE, 32'h0);
    chk("release default", 32'd1000, rd);
    bus(1'b0, REG_CTRL, 32'h0);
    chk("ctrl reset", 32'h30, rd);
    bus(1'b0, 8'h38, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, REG_RELEASE_BASE, 32'h0fffffff);
    bus(1'b0, REG_RELEASE_BASE, 32'h0);
    chk("release clamp", 32'd1800000, rd);
    bus(1'b1, REG_RELEASE_BASE, 32'd5);
  endtask

  task automatic t_expire();
    arm();
    wait_st(ST_ACTIVE, 20);
    chk("active out", 32'h1, {31'h0, active_o});
    bus(1'b0, REG_REC_INFO, 32'h0);
    chk("record info", 32'h80000104, rd & 32'h80000f77);
    bus(1'b0, REG_REC_REMAIN, 32'h0);
    chk("record remain", 32'd5, rd);
    wait_st(ST_NORMAL, 8 * TK);
    chk("trip after expiry", 32'h0, {31'h0, trip_o});
    chk("remain idle", 32'h0, {11'h0, remain});
  endtask

  task automatic t_trip();
    int n;
    arm();
    wait_st(ST_ACTIVE, 20);
    @(posedge core_clk);
    start_lvl <= 1'b1;
    n = 0;
    while (trip_o !== 1'b1 && n < 10)
    begin
      @(negedge core_clk);
      n++;
    end
    chk("trip out", 32'h1, {31'h0, trip_o});
    // the trip must lead the state change, so the state is still active here
    chk("state at trip", {29'h0, ST_ACTIVE}, {29'h0, cond});
    wait_st(ST_TRIP, 4);
    @(posedge core_clk);
    start_lvl <= 1'b0;
    wait_st(ST_NORMAL, 8 * TK);
  endtask

  task automatic t_block();
    @(posedge core_clk);
    block_lvl <= 1'b1;
    wait_st(ST_BLOCKED, 10);
    arm();
    repeat (20) @(negedge core_clk);
    chk("blocked state", {29'h0, ST_BLOCKED}, {29'h0, cond});
    chk("blocked active", 32'h0, {31'h0, active_o});
    @(posedge core_clk);
    block_lvl <= 1'b0;
    wait_st(ST_NORMAL, 10);
  endtask

  task automatic t_group();
    bus(1'b1, REG_RELEASE_BASE + 8'h04, 32'd200);
    arm();
    wait_st(ST_ACTIVE, 20);
    @(posedge core_clk);
    sg <= 3'h1;
    repeat (10 * TK) @(negedge core_clk);
    chk("group 1 holds", {29'h0, ST_ACTIVE}, {29'h0, cond});
    chk("group 1 remain", 32'h1, {31'h0, remain > 21'd180 && remain <= 21'd200});
    @(posedge core_clk);
    sg <= 3'h0;
    wait_st(ST_NORMAL, 2 * TK);
  endtask

  task automatic t_events();
    bus(1'b1, REG_CTRL, 32'h110);
    bus(1'b1, REG_IRQ_STATUS, 32'hff);
    bus(1'b1, REG_IRQ_MASK, 32'h10);
    bus(1'b1, REG_TIME, 32'h1000);
    seen_p = 8'h00;
    seen_s = 8'h00;
    // irq follows registered status, so look only once the writes have settled
    @(negedge core_clk);
    chk("irq idle", 32'h0, {31'h0, irq});
    arm();
    wait_st(ST_ACTIVE, 20);
    repeat (3) @(negedge core_clk);
    chk("irq raised", 32'h1, {31'h0, irq});
    wait_st(ST_NORMAL, 8 * TK);
    repeat (3) @(negedge core_clk);
    chk("event pulses", 32'h33, {24'h0, seen_p});
    chk("events stored", 32'h11, {24'h0, seen_s});
    chk("event stamp", 32'h1, {31'h0, stamp >= 32'h1004 && stamp <= 32'h1007});
    bus(1'b0, REG_LAST_EVENT, 32'h0);
    chk("last event", 32'h4, rd);
    bus(1'b0, REG_LAST_STAMP, 32'h0);
    chk("last stamp", 32'h800, {1'b0, rd[31:1]});
    bus(1'b0, REG_CNT_BASE, 32'h0);
    chk("init count", 32'h1, rd);
    bus(1'b0, REG_CNT_BASE + 8'h08, 32'h0);
    chk("active count", 32'h1, rd);
    bus(1'b0, REG_IRQ_STATUS, 32'h0);
    chk("irq status", 32'h33, rd);
    bus(1'b1, REG_IRQ_STATUS, 32'h10);
    @(negedge core_clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    bus(1'b1, REG_IRQ_MASK, 32'h20);
    @(negedge core_clk);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    bus(1'b1, REG_IRQ_STATUS, 32'hff);
    @(negedge core_clk);
    chk("irq all clear", 32'h0, {31'h0, irq});
    bus(1'b1, REG_CTRL, 32'h30);
  endtask

  task automatic t_force();
    logic [2:0] es [4];
    es = '{ST_NORMAL, ST_BLOCKED, ST_ACTIVE, ST_TRIP};
    for (int f = 0; f < 4; f++)
    begin
      bus(1'b1, REG_CTRL, 32'h31 | {29'h0, f[1:0], 1'b0});
      wait_st(es[f], 4);
    end
    chk("forced trip out", 32'h1, {31'h0, trip_o});
    // force value without the enable must leave the function alone
    bus(1'b1, REG_CTRL, 32'h36);
    wait_st(ST_NORMAL, 4);
    bus(1'b1, REG_CTRL, 32'h30);
  endtask

  initial
  begin
    seen_p = 8'h00;
    seen_s = 8'h00;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_reset();
    t_expire();
    t_trip();
    t_block();
    t_group();
    t_events();
    t_force();
    tally_and_finish();
  end
endmodule
`default_nettype wire

/* verilog/cofg_guard.sv */
// close-onto-fault guard: arm window, instant trip, events, counters, records
`timescale 1ns/1ps
`default_nettype none
module cofg_guard
  import cofg_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic guard_activate_in,
  input wire logic guard_block_in,
  input wire logic guard_function_in,
  input wire logic [SG_W-1:0] setting_group_select,
  output logic guard_active_out,
  output logic guard_trip_out,
  output logic [RT_W-1:0] guard_time_remaining,
  output logic [2:0] condition_state,
  output logic [EV_W-1:0] event_pulse,
  output logic [EV_W-1:0] event_store,
  output logic [STAMP_W-1:0] event_stamp,
  output logic irq
);

  localparam int TW = $clog2(TICK_CYCLES_P + 1);

  logic [2:0] act_sync;
  logic [1:0] blk_sync;
  logic [1:0] fcn_sync;
  logic act_rise;
  logic blk_s;
  logic fcn_s;
  logic [TW-1:0] tick_cnt;
  logic ms_tick;
  logic [STAMP_W-1:0] time_ms;
  logic [RT_W-1:0] release_ms [SG_COUNT];
  logic [RT_W-1:0] rel_sel;
  logic [RT_W-1:0] elapsed_ms;
  logic [RT_W-1:0] remain_now;
  logic expired;
  logic arm;
  cofg_state_type state;
  cofg_state_type eff_state;
  logic force_en;
  cofg_force_type force_sel;
  logic [1:0] store_sel;
  logic [FLAG_COUNT-1:0] flag;
  logic [FLAG_COUNT-1:0] flag_q;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] store_mask;
  logic [CNT_W-1:0] cnt [FLAG_COUNT];
  logic [EV_W-1:0] irq_status;
  logic [EV_W-1:0] irq_mask;
  logic [2:0] last_code;
  logic [STAMP_W-1:0] last_stamp;
  logic [REC_AGE_W-1:0] rec_sel;
  logic [REC_W-1:0] rec_data;
  logic rec_valid;
  logic [REC_AGE_W-1:0] rec_count;
  logic ack;
  logic wr_en;
  logic cnt_clr;
  logic [31:0] rd_mux;

  // activate, block and function arrive from pins; inputs are binary only
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      act_sync <= '0;
      blk_sync <= '0;
      fcn_sync <= '0;
    end
    else
    begin
      act_sync <= {act_sync[1:0], guard_activate_in};
      blk_sync <= {blk_sync[0], guard_block_in};
      fcn_sync <= {fcn_sync[0], guard_function_in};
    end
  end

  assign act_rise = act_sync[1] & ~act_sync[2];
  assign blk_s = blk_sync[1];
  assign fcn_s = fcn_sync[1];

  // one millisecond base shared by the window timer and the time stamps
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      tick_cnt <= '0;
    else if (ms_tick)
      tick_cnt <= '0;
    else
      tick_cnt <= tick_cnt + 1'b1;
  end

  assign ms_tick = tick_cnt == TW'(TICK_CYCLES_P - 1);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      time_ms <= '0;
    else if (wr_en && avs_address == REG_TIME)
      time_ms <= avs_writedata;
    else if (ms_tick)
      time_ms <= time_ms + 1'b1;
  end

  for (genvar g = 0; g < SG_COUNT; g++)
  begin : g_group
    always_ff @(posedge core_clk)
    begin
      if (!rst_n)
        release_ms[g] <= RELEASE_DEFAULT_MS;
      else if (wr_en && avs_address[7:5] == REG_RELEASE_BASE[7:5] &&
               avs_address[4:2] == SG_W'(g))
        release_ms[g] <= (avs_writedata > 32'(RELEASE_MAX_MS)) ?
                         RELEASE_MAX_MS : avs_writedata[RT_W-1:0];
    end
  end

  // the selected group is read live, so a change takes effect mid-window
  assign rel_sel = release_ms[setting_group_select];
  assign expired = elapsed_ms >= rel_sel;
  assign remain_now = expired ? '0 : rel_sel - elapsed_ms;
  assign arm = (state == ST_NORMAL || state == ST_BLOCKED) && !blk_s && act_rise;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      elapsed_ms <= '0;
    else if (arm)
      elapsed_ms <= '0;
    else if (ms_tick && state != ST_NORMAL && state != ST_BLOCKED &&
             elapsed_ms != RELEASE_MAX_MS)
      elapsed_ms <= elapsed_ms + 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      state <= ST_NORMAL;
    else
    begin
      case (state)
        ST_NORMAL, ST_BLOCKED:
          if (blk_s)
            state <= ST_BLOCKED;
          else if (act_rise)
            state <= ST_INIT;
          else
            state <= ST_NORMAL;
        ST_INIT, ST_ACTIVE:
          if (blk_s)
            state <= ST_BLOCKED;
          else if (fcn_s)
            state <= ST_TRIP;
          else if (expired)
            state <= ST_NORMAL;
          else
            state <= ST_ACTIVE;
        ST_TRIP:
          // a given trip holds while the function input stays up and block is low
          if (blk_s)
            state <= ST_BLOCKED;
          else if (fcn_s)
            state <= ST_TRIP;
          else if (expired)
            state <= ST_NORMAL;
          else
            state <= ST_ACTIVE;
        default:
          state <= ST_NORMAL;
      endcase
    end
  end

  always_comb
  begin
    eff_state = state;
    if (force_en)
    begin
      case (force_sel)
        FORCE_BLOCKED: eff_state = ST_BLOCKED;
        FORCE_ACTIVE: eff_state = ST_ACTIVE;
        FORCE_TRIP: eff_state = ST_TRIP;
        default: eff_state = ST_NORMAL;
      endcase
    end
  end

  assign condition_state = eff_state;
  assign guard_active_out = eff_state == ST_INIT || eff_state == ST_ACTIVE ||
                            eff_state == ST_TRIP;
  // combinational path so the trip leaves in the cycle the start is seen
  assign guard_trip_out = eff_state == ST_TRIP ||
                          (!force_en && !blk_s && fcn_s &&
                           (state == ST_INIT || state == ST_ACTIVE));

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      guard_time_remaining <= '0;
    else if (state == ST_NORMAL || state == ST_BLOCKED)
      guard_time_remaining <= '0;
    else
      guard_time_remaining <= remain_now;
  end

  assign flag[FLAG_INIT] = eff_state == ST_INIT;
  assign flag[FLAG_BLOCK] = eff_state == ST_BLOCKED;
  assign flag[FLAG_ACTIVE] = guard_active_out;
  assign flag[FLAG_TRIP] = guard_trip_out;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      flag_q <= '0;
    else
      flag_q <= flag;
  end

  assign cnt_clr = wr_en && avs_address == REG_CTRL && avs_writedata[CTRL_CNT_CLR_BIT];

  for (genvar i = 0; i < FLAG_COUNT; i++)
  begin : g_flag
    assign ev[2*i] = flag[i] & ~flag_q[i];
    assign ev[2*i+1] = ~flag[i] & flag_q[i];
    assign store_mask[2*i] = store_sel[0];
    assign store_mask[2*i+1] = store_sel[1];
    // an ON event in the clearing cycle is still counted
    always_ff @(posedge core_clk)
    begin
      if (!rst_n)
        cnt[i] <= '0;
      else
        cnt[i] <= (cnt_clr ? '0 : cnt[i]) + CNT_W'(ev[2*i]);
    end
  end

  function automatic logic [2:0] top_event(input logic [EV_W-1:0] v);
    logic [2:0] code;
    code = '0;
    for (int k = 0; k < EV_W; k++)
      if (v[k])
        code = 3'(k);
    return code;
  endfunction

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      event_pulse <= '0;
      event_store <= '0;
      event_stamp <= '0;
    end
    else
    begin
      event_pulse <= ev;
      event_store <= ev & store_mask;
      if (|ev)
        event_stamp <= time_ms;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      last_code <= '0;
      last_stamp <= '0;
    end
    else if (|(ev & store_mask))
    begin
      last_code <= top_event(ev & store_mask);
      last_stamp <= time_ms;
    end
  end

  cofg_record_store #(
    .DEPTH(REC_DEPTH),
    .W(REC_W)
  ) u_records (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wr(ev[2*FLAG_ACTIVE]),
    .wr_data({time_ms, 3'(2*FLAG_ACTIVE), setting_group_select, remain_now,
              elapsed_ms}),
    .rd_age(rec_sel),
    .rd_data(rec_data),
    .rd_valid(rec_valid),
    .count(rec_count)
  );

  // write-one-to-clear; a new event in the clearing cycle stays set
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      irq_status <= '0;
    else if (wr_en && avs_address == REG_IRQ_STATUS)
      irq_status <= (irq_status & ~avs_writedata[EV_W-1:0]) | ev;
    else
      irq_status <= irq_status | ev;
  end

  assign irq = |(irq_status & irq_mask);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      force_en <= 1'b0;
      force_sel <= FORCE_NORMAL;
      store_sel <= STORE_SEL_RESET;
      irq_mask <= '0;
      rec_sel <= '0;
    end
    else if (wr_en)
    begin
      if (avs_address == REG_CTRL)
      begin
        force_en <= avs_writedata[CTRL_FORCE_EN_BIT];
        force_sel <= cofg_force_type'(avs_writedata[CTRL_FORCE_LSB +: 2]);
        store_sel <= avs_writedata[CTRL_STORE_LSB +: 2];
      end
      else if (avs_address == REG_IRQ_MASK)
        irq_mask <= avs_writedata[EV_W-1:0];
      else if (avs_address == REG_REC_SEL)
        rec_sel <= avs_writedata[REC_AGE_W-1:0];
    end
  end

  // one wait state: data is registered in the first cycle, handed over in the second
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      ack <= 1'b0;
    else
      ack <= (avs_read | avs_write) & ~ack;
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign wr_en = avs_write & ack;

  always_comb
  begin
    rd_mux = '0;
    if (avs_address == REG_CTRL)
      rd_mux = {26'h0, store_sel, 1'b0, force_sel, force_en};
    else if (avs_address == REG_STATUS)
      rd_mux = {21'h0, setting_group_select, 1'b0, force_en, guard_trip_out,
                guard_active_out, 1'b0, eff_state};
    else if (avs_address == REG_REMAIN)
      rd_mux = 32'(guard_time_remaining);
    else if (avs_address == REG_ELAPSED)
      rd_mux = 32'(elapsed_ms);
    else if (avs_address == REG_IRQ_STATUS)
      rd_mux = 32'(irq_status);
    else if (avs_address == REG_IRQ_MASK)
      rd_mux = 32'(irq_mask);
    else if (avs_address == REG_TIME)
      rd_mux = time_ms;
    else if (avs_address == REG_LAST_EVENT)
      rd_mux = 32'(last_code);
    else if (avs_address == REG_LAST_STAMP)
      rd_mux = last_stamp;
    else if (avs_address == REG_REC_SEL)
      rd_mux = 32'(rec_sel);
    else if (avs_address == REG_REC_INFO)
      rd_mux = {rec_valid, 19'h0, rec_count, 1'b0,
                rec_data[2*RT_W +: SG_W], 1'b0, rec_data[2*RT_W+SG_W +: 3]};
    else if (avs_address == REG_REC_STAMP)
      rd_mux = rec_data[REC_W-1 -: STAMP_W];
    else if (avs_address == REG_REC_REMAIN)
      rd_mux = 32'(rec_data[RT_W +: RT_W]);
    else if (avs_address == REG_REC_ELAPSED)
      rd_mux = 32'(rec_data[RT_W-1:0]);
    else if (avs_address[7:4] == REG_CNT_BASE[7:4])
      rd_mux = cnt[avs_address[3:2]];
    else if (avs_address[7:5] == REG_RELEASE_BASE[7:5])
      rd_mux = 32'(release_ms[avs_address[4:2]]);
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      avs_readdata <= '0;
    else if (avs_read && !ack)
      avs_readdata <= rd_mux;
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  arm_on_edge_a: assert property (
    arm |=> state == ST_INIT && elapsed_ms == '0)
    else $error("rising activate did not arm the window");
  block_no_arm_a: assert property (
    blk_s && (state == ST_NORMAL || state == ST_BLOCKED) |=> state == ST_BLOCKED)
    else $error("window started while blocked");
  instant_trip_a: assert property (
    !force_en && !blk_s && fcn_s && state == ST_ACTIVE |-> guard_trip_out ##1 state == ST_TRIP)
    else $error("function input in window did not trip at once");
  expiry_normal_a: assert property (
    state == ST_ACTIVE && !blk_s && !fcn_s && expired |=> state == ST_NORMAL && !guard_trip_out)
    else $error("expired window did not return to normal");
  window_bound_a: assert property (
    state == ST_ACTIVE |-> elapsed_ms < rel_sel || $past(elapsed_ms) < $past(rel_sel))
    else $error("window ran past release time");
  force_trip_a: assert property (
    force_en && force_sel == FORCE_TRIP |-> guard_trip_out && condition_state == ST_TRIP)
    else $error("forced trip not shown");
  remain_track_a: assert property (
    state == ST_ACTIVE |=> guard_time_remaining == $past(remain_now))
    else $error("remaining time not from selected group");
  active_events_a: assert property (
    $rose(guard_active_out) |=> event_pulse[2*FLAG_ACTIVE] ##[1:300] 1)
    else $error("active ON event missing");
  stamp_capture_a: assert property (
    |ev |=> event_stamp == $past(time_ms))
    else $error("event stamp not captured");
  init_count_a: assert property (
    ev[2*FLAG_INIT] && !cnt_clr |=> cnt[FLAG_INIT] == $past(cnt[FLAG_INIT]) + 1'b1)
    else $error("init counter did not advance");
  state_legal_a: assert property (
    condition_state <= 3'(ST_BLOCKED))
    else $error("condition outside five states");

  trip_in_window_c: cover property (state == ST_ACTIVE ##1 state == ST_TRIP);
  window_expiry_c: cover property (state == ST_ACTIVE ##1 state == ST_NORMAL);
  block_in_window_c: cover property (state == ST_ACTIVE ##1 state == ST_BLOCKED);
  record_full_c: cover property (rec_count == REC_AGE_W'(REC_DEPTH) && ev[2*FLAG_ACTIVE]);

endmodule
`default_nettype wire

/* verilog/cofg_record_store.sv */
// ring of the most recent activation records, read back by age
`timescale 1ns/1ps
`default_nettype none
module cofg_record_store
  import cofg_pkg::*;
#(
  parameter int DEPTH = REC_DEPTH,
  parameter int W = REC_W
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wr,
  input wire logic [W-1:0] wr_data,
  input wire logic [REC_AGE_W-1:0] rd_age,
  output logic [W-1:0] rd_data,
  output logic rd_valid,
  output logic [REC_AGE_W-1:0] count
);

  logic [W-1:0] mem [DEPTH];
  logic [REC_AGE_W-1:0] wptr;
  logic [REC_AGE_W-1:0] newest;
  logic [REC_AGE_W-1:0] rd_idx;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      wptr <= '0;
    else if (wr)
      wptr <= (wptr == REC_AGE_W'(DEPTH - 1)) ? '0 : wptr + 1'b1;
  end

  // oldest record is overwritten once the ring is full
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      count <= '0;
    else if (wr && count != REC_AGE_W'(DEPTH))
      count <= count + 1'b1;
  end

  for (genvar i = 0; i < DEPTH; i++)
  begin : g_entry
    always_ff @(posedge core_clk)
    begin
      if (wr && wptr == REC_AGE_W'(i))
        mem[i] <= wr_data;
    end
  end

  assign newest = (wptr == '0) ? REC_AGE_W'(DEPTH - 1) : wptr - 1'b1;
  assign rd_idx = (newest >= rd_age) ? newest - rd_age : newest + REC_AGE_W'(DEPTH) - rd_age;
  assign rd_valid = rd_age < count;
  assign rd_data = rd_valid ? mem[rd_idx] : '0;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  record_depth_a: assert property (
    wr && count < REC_AGE_W'(DEPTH) |=> count == $past(count) + 1'b1)
    else $error("record count did not grow on store");
  record_cap_a: assert property (
    count <= REC_AGE_W'(DEPTH))
    else $error("record count exceeds depth");

endmodule
`default_nettype wire
